// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb
   import tlrb_pkg::*;
;
   logic       clk_i;
   logic       rst_n_i;
   logic       rd_en;
   logic       wr_en;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   tlrb_conv_t lconv;
   tlrb_conv_t rconv;
   logic [7:0] low_int;
   logic       shut;
   logic       warn;
   logic       tmo;
   logic [7:0] v;
   int         error_cnt;
   int         comparisons;
   logic [7:0] ra [7] = '{8'h14, 8'h15, 8'h19, 8'h20, 8'h21, 8'h22, 8'h00};
   logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h6C, 8'h55, 8'h0A, 8'h01, 8'h00};
   logic [2:0] cc [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

   tlrb_temp_limit_bank u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en), .wr_en_i(wr_en),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .local_conv_i(lconv),
      .rmt_conv_i(rconv), .rmt_low_limit_int_i(low_int),
      .overtemp_shutdown_output_o(shut), .limit_warning_o(warn),
      .bus_timeout_enable_o(tmo));
   tlrb_host_model u_host (
      .clk_i(clk_i), .rdata_i(rdata), .rd_en_o(rd_en), .wr_en_o(wr_en),
      .addr_o(addr), .wdata_o(wdata));

   // Free-running 8 ns clock.
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Read a register and compare it in one go.
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask

   // One conversion pulse; the extra edge lets registered outputs land.
   task automatic conv(input logic rmt, input logic [7:0] w, input logic [3:0] f);
      @(negedge clk_i);
      if (rmt) rconv = '{1'b1, w, f};
      else lconv = '{1'b1, w, f};
      @(negedge clk_i);
      rconv.done = 1'b0;
      lconv.done = 1'b0;
      @(negedge clk_i);
   endtask

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // A hang is cut off well beyond the under two hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      rst_n_i = 1'b0;
      lconv   = '0;
      rconv   = '0;
      low_int = 8'h20;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      // Reset values of the whole table.
      for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
      chk("timeout en", 8'h00, {7'h00, tmo});
      // Stored bytes, read-only fraction, unmapped pointer, timeout bit.
      u_host.wr(8'h14, 8'hA5);
      rchk(8'h14, 8'hA5);
      u_host.wr(8'h15, 8'hFF);
      rchk(8'h15, 8'h00);
      rchk(8'h30, 8'h00);
      u_host.wr(8'h22, 8'h81);
      chk("timeout en", 8'h01, {7'h00, tmo});
      u_host.wr(8'h22, 8'h01);
      chk("timeout en", 8'h00, {7'h00, tmo});
      // High byte first freezes the fraction until it is read.
      conv(1'b0, 8'h20, 4'h9);
      rchk(8'h00, 8'h20);
      conv(1'b0, 8'h21, 4'h3);
      rchk(8'h15, 8'h90);
      conv(1'b0, 8'h22, 4'h5);
      rchk(8'h00, 8'h22);
      rchk(8'h15, 8'h50);
      // Low byte first freezes the high byte; another read drops it.
      rchk(8'h15, 8'h50);
      conv(1'b0, 8'h23, 4'h6);
      rchk(8'h00, 8'h22);
      rchk(8'h15, 8'h60);
      rchk(8'h14, 8'hA5);
      conv(1'b0, 8'h24, 4'h7);
      rchk(8'h00, 8'h24);
      // Local shutdown with the default limit and deadband.
      conv(1'b0, 8'h56, 4'h0);
      chk("shutdown", 8'h01, {7'h00, shut});
      conv(1'b0, 8'h4C, 4'h0);
      chk("shutdown", 8'h01, {7'h00, shut});
      conv(1'b0, 8'h4A, 4'h0);
      chk("shutdown", 8'h00, {7'h00, shut});
      // Remote shutdown against a written limit.
      u_host.wr(8'h19, 8'h30);
      conv(1'b1, 8'h31, 4'h0);
      chk("shutdown", 8'h01, {7'h00, shut});
      conv(1'b1, 8'h26, 4'h0);
      chk("shutdown", 8'h01, {7'h00, shut});
      conv(1'b1, 8'h25, 4'h0);
      chk("shutdown", 8'h00, {7'h00, shut});
      // Warning after 1..4 readings below 20.8; exactly 20.8 is not below.
      u_host.wr(8'h14, 8'h80);
      for (int c = 0; c < 4; c++) begin
         u_host.wr(8'h22, {4'h0, cc[c], 1'b1});
         conv(1'b1, 8'h20, 4'h8);
         chk("warning", 8'h00, {7'h00, warn});
         for (int k = 0; k < c; k++) begin
            conv(1'b1, 8'h20, 4'h7);
            chk("warning", 8'h00, {7'h00, warn});
         end
         conv(1'b1, 8'h20, 4'h7);
         chk("warning", 8'h01, {7'h00, warn});
      end
      tally_and_finish();
   end
endmodule

// ---- bench/tlrb_host_model.sv ----
`timescale 1ns/1ns
// Host side of the register port: requests change on falling edges so
// the rising edge that takes them always sees settled values.
module tlrb_host_model (
   // Clock and read data.
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   // Strobes, pointer and write data.
   output logic            rd_en_o,
   output logic            wr_en_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o
);
   // Idle values; the pointer parks on an unmapped place.
   initial begin
      rd_en_o = 1'b0;
      wr_en_o = 1'b0;
      addr_o  = 8'hFF;
      wdata_o = 8'h00;
   end

   // One write; data is inverted afterwards so a late sample would show.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_en_o = 1'b1;
      addr_o  = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      wdata_o = ~d;
   endtask

   // One read; the answer is registered, so it is taken a cycle later.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      rd_en_o = 1'b1;
      addr_o  = a;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      addr_o  = ~a;
      d       = rdata_i;
   endtask
endmodule

// ---- logic/tlrb_params.svh ----
`ifndef TLRB_PARAMS_SVH
`define TLRB_PARAMS_SVH

// Pointer addresses of the registers held in this bank.
`define TLRB_OFS_LOCAL_HIGH      8'h00
`define TLRB_OFS_RMT_LOW_FRAC    8'h14
`define TLRB_OFS_LOCAL_FRAC      8'h15
`define TLRB_OFS_RMT_SHUT        8'h19
`define TLRB_OFS_LOCAL_SHUT      8'h20
`define TLRB_OFS_DEADBAND        8'h21
`define TLRB_OFS_FAULT_CFG       8'h22

// Reset values.
`define TLRB_RST_RMT_LOW_FRAC    8'h00
`define TLRB_RST_LOCAL_FRAC      8'h00
`define TLRB_RST_LOCAL_HIGH      8'h00
`define TLRB_RST_RMT_SHUT        8'h6C
`define TLRB_RST_LOCAL_SHUT      8'h55
`define TLRB_RST_DEADBAND        8'h0A
`define TLRB_RST_FAULT_CFG       8'h01

// Field positions.
`define TLRB_FRAC_MSB            7
`define TLRB_FRAC_LSB            4
`define TLRB_CFG_TIMEOUT_BIT     7
`define TLRB_CFG_COUNT_MSB       3
`define TLRB_CFG_COUNT_LSB       1

// Largest number of consecutive faults that can be asked for.
`define TLRB_FAULT_MAX           3'h4

`endif

// ---- logic/tlrb_pkg.sv ----
package tlrb_pkg;

   // Read-lock state of the local temperature byte pair.
   typedef enum logic [1:0] {
      TLRB_UNLOCKED   = 2'b00,
      TLRB_HIGH_FIRST = 2'b01,
      TLRB_LOW_FIRST  = 2'b10
   } tlrb_lock_t;

   // One finished conversion: 8-bit integer and 4-bit fraction.
   typedef struct packed {
      logic       done;
      logic [7:0] whole;
      logic [3:0] frac;
   } tlrb_conv_t;

   // Whole state of the bank.
   typedef struct packed {
      logic [7:0] rmt_low_frac;
      logic [7:0] local_frac;
      logic [7:0] local_high;
      logic [7:0] rmt_shut;
      logic [7:0] local_shut;
      logic [7:0] deadband;
      logic [7:0] fault_cfg;
      tlrb_lock_t lock;
      logic [2:0] fault_cnt;
      logic       local_hot;
      logic       rmt_hot;
      logic       shutdown;
      logic       alert;
      logic [7:0] rdata;
   } tlrb_state_t;

endpackage

// ---- logic/tlrb_temp_limit_bank.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Bits 7..4 of the remote low-limit fraction byte are the sixteenth-degree part of the remote low limit and take part in the low-limit compare.
// - The local temperature fraction byte is read-only and its upper nibble holds the sixteenth-degree part of the local temperature.
// - Each finished local conversion loads the fraction byte unless that byte is locked.
// - Reading the high byte first freezes the low byte until the low byte is read.
// - Reading the low byte first freezes the high byte until the high byte is read.
// - Reading any other register drops the lock.
// - The remote shutdown limit is a whole-degree limit against the remote reading, reset 6Ch.
// - The local shutdown limit is a whole-degree limit against the local reading, reset 55h.
// - The deadband register is the whole-degree hysteresis of the shutdown output, reset 0Ah.
// - The fault config holds timeout enable at bit 7, fault count at bits 3..1, bit 0 resets to one.
// - Timeout enable at one turns the bus timeout on, at zero off.
// - The count field picks how many successive out-of-limit readings raise the warning.
`include "tlrb_params.svh"

module tlrb_temp_limit_bank
   import tlrb_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Pointer-addressed register port from the bus engine.
   input  wire logic       rd_en_i,
   input  wire logic       wr_en_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o,
   // Conversion results and the remote low-limit whole degrees.
   input  wire tlrb_conv_t local_conv_i,
   input  wire tlrb_conv_t rmt_conv_i,
   input  wire logic [7:0] rmt_low_limit_int_i,
   // Status outputs.
   output logic            overtemp_shutdown_output_o,
   output logic            limit_warning_o,
   output logic            bus_timeout_enable_o
);

   localparam tlrb_state_t RST_STATE = '{
      rmt_low_frac: `TLRB_RST_RMT_LOW_FRAC,
      local_frac:   `TLRB_RST_LOCAL_FRAC,
      local_high:   `TLRB_RST_LOCAL_HIGH,
      rmt_shut:     `TLRB_RST_RMT_SHUT,
      local_shut:   `TLRB_RST_LOCAL_SHUT,
      deadband:     `TLRB_RST_DEADBAND,
      fault_cfg:    `TLRB_RST_FAULT_CFG,
      lock:         TLRB_UNLOCKED,
      fault_cnt:    3'h0,
      local_hot:    1'b0,
      rmt_hot:      1'b0,
      shutdown:     1'b0,
      alert:        1'b0,
      rdata:        8'h00
   };

   tlrb_state_t state_ff;
   tlrb_state_t nxt_state;

   logic       rd_high;
   logic       rd_low;
   logic       rmt_below;
   logic [2:0] fault_need;
   logic [2:0] cnt_field;
   logic       addr_mapped;

   // Pointers that hold a register here; any other pointer must read back
   // as zero, so a host probing a hole never sees stale data from a prior read.
   assign addr_mapped = (addr_i == `TLRB_OFS_LOCAL_HIGH)
      || (addr_i == `TLRB_OFS_RMT_LOW_FRAC)
      || (addr_i == `TLRB_OFS_LOCAL_FRAC)
      || (addr_i == `TLRB_OFS_RMT_SHUT)
      || (addr_i == `TLRB_OFS_LOCAL_SHUT)
      || (addr_i == `TLRB_OFS_DEADBAND)
      || (addr_i == `TLRB_OFS_FAULT_CFG);

   // Read decode of the two halves of the local reading.
   assign rd_high = rd_en_i && (addr_i == `TLRB_OFS_LOCAL_HIGH);
   assign rd_low  = rd_en_i && (addr_i == `TLRB_OFS_LOCAL_FRAC);

   // Remote reading against the low limit; whole degrees and bits 7..4 of the fraction byte count.
   assign rmt_below = {rmt_conv_i.whole, rmt_conv_i.frac}
      < {rmt_low_limit_int_i,
         state_ff.rmt_low_frac[`TLRB_FRAC_MSB:`TLRB_FRAC_LSB]};

   // Count codes 0,1,3,7 map to 1..4 as the number of set bits plus one.
   assign cnt_field  = state_ff.fault_cfg[`TLRB_CFG_COUNT_MSB:`TLRB_CFG_COUNT_LSB];
   assign fault_need = 3'(cnt_field[0]) + 3'(cnt_field[1]) + 3'(cnt_field[2])
      + 3'h1;

   // Hysteretic over-limit test; widened to nine bits so a reading plus deadband
   // above 255 cannot wrap and release the output too early.
   function automatic logic hot_next(input logic hot, input logic [7:0] temp,
                                     input logic [7:0] limit,
                                     input logic [7:0] band);
      logic [8:0] temp_plus;
      temp_plus = {1'b0, temp} + {1'b0, band};
      if (temp > limit) begin
         hot_next = 1'b1;
      end else if (temp_plus < {1'b0, limit}) begin
         hot_next = 1'b0;
      end else begin
         hot_next = hot;
      end
   endfunction

   // Next-state logic for the whole bank.
   always_comb begin
      nxt_state = state_ff;

      // Register writes; read-only bytes ignore writes.
      if (wr_en_i) begin
         unique case (addr_i)
            `TLRB_OFS_RMT_LOW_FRAC: nxt_state.rmt_low_frac = wdata_i;
            `TLRB_OFS_RMT_SHUT:     nxt_state.rmt_shut     = wdata_i;
            `TLRB_OFS_LOCAL_SHUT:   nxt_state.local_shut   = wdata_i;
            `TLRB_OFS_DEADBAND:     nxt_state.deadband     = wdata_i;
            `TLRB_OFS_FAULT_CFG:    nxt_state.fault_cfg    = wdata_i;
            default: ;
         endcase
      end

      // Lock tracking; a repeat read of the same half keeps the lock.
      if (rd_high) begin
         nxt_state.lock = (state_ff.lock == TLRB_LOW_FIRST) ? TLRB_UNLOCKED
                                                            : TLRB_HIGH_FIRST;
      end else if (rd_low) begin
         nxt_state.lock = (state_ff.lock == TLRB_HIGH_FIRST) ? TLRB_UNLOCKED
                                                             : TLRB_LOW_FIRST;
      end else if (rd_en_i) begin
         nxt_state.lock = TLRB_UNLOCKED;
      end

      // Updates are gated by the lock that holds after this cycle's read,
      // so a read and a conversion in one cycle never split a pair.
      if (local_conv_i.done) begin
         if (nxt_state.lock != TLRB_HIGH_FIRST) begin
            nxt_state.local_frac = {local_conv_i.frac, 4'h0};
         end
         if (nxt_state.lock != TLRB_LOW_FIRST) begin
            nxt_state.local_high = local_conv_i.whole;
         end
         nxt_state.local_hot = hot_next(state_ff.local_hot, local_conv_i.whole,
                                        state_ff.local_shut, state_ff.deadband);
      end

      // Remote channel: shutdown compare and consecutive low-limit faults.
      if (rmt_conv_i.done) begin
         nxt_state.rmt_hot = hot_next(state_ff.rmt_hot, rmt_conv_i.whole,
                                      state_ff.rmt_shut, state_ff.deadband);
         if (rmt_below) begin
            if (state_ff.fault_cnt != `TLRB_FAULT_MAX) begin
               nxt_state.fault_cnt = state_ff.fault_cnt + 3'h1;
            end
            nxt_state.alert = (state_ff.fault_cnt + 3'h1) >= fault_need;
         end else begin
            nxt_state.fault_cnt = 3'h0;
            nxt_state.alert     = 1'b0;
         end
      end
      nxt_state.shutdown = nxt_state.local_hot || nxt_state.rmt_hot;

      // Read data, one cycle after the strobe; unmapped pointers read zero.
      if (rd_en_i) begin
         unique case (addr_i)
            `TLRB_OFS_LOCAL_HIGH:   nxt_state.rdata = state_ff.local_high;
            `TLRB_OFS_RMT_LOW_FRAC: nxt_state.rdata = state_ff.rmt_low_frac;
            `TLRB_OFS_LOCAL_FRAC:   nxt_state.rdata = state_ff.local_frac;
            `TLRB_OFS_RMT_SHUT:     nxt_state.rdata = state_ff.rmt_shut;
            `TLRB_OFS_LOCAL_SHUT:   nxt_state.rdata = state_ff.local_shut;
            `TLRB_OFS_DEADBAND:     nxt_state.rdata = state_ff.deadband;
            `TLRB_OFS_FAULT_CFG:    nxt_state.rdata = state_ff.fault_cfg;
            default:                nxt_state.rdata = 8'h00;
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_ff <= RST_STATE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs come straight from the state register.
   assign rdata_o                    = state_ff.rdata;
   assign overtemp_shutdown_output_o = state_ff.shutdown;
   assign limit_warning_o            = state_ff.alert;
   assign bus_timeout_enable_o       = state_ff.fault_cfg[`TLRB_CFG_TIMEOUT_BIT];

   // Checks on the register behaviour.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   shut_reset_a: assert property ($past(!rst_n_i) |-> state_ff.rmt_shut == 8'h6C
      && state_ff.local_shut == 8'h55)
      else $error("shutdown limits not at reset value");
   band_reset_a: assert property ($past(!rst_n_i) |-> state_ff.deadband == 8'h0A
      && state_ff.fault_cfg == 8'h01)
      else $error("deadband or fault config not at reset value");
   frac_update_a: assert property (state_ff.lock == TLRB_UNLOCKED && !rd_en_i
      && local_conv_i.done |=> state_ff.local_frac == {$past(local_conv_i.frac), 4'h0})
      else $error("fraction byte missed a conversion");
   frac_readonly_a: assert property (wr_en_i && addr_i == `TLRB_OFS_LOCAL_FRAC
      && !local_conv_i.done |=> $stable(state_ff.local_frac))
      else $error("write changed the read-only fraction byte");
   low_lock_a: assert property (rd_high && state_ff.lock == TLRB_UNLOCKED
      ##1 (!rd_en_i) [*2] |=> $stable(state_ff.local_frac))
      else $error("locked low byte changed");
   high_lock_a: assert property (state_ff.lock == TLRB_LOW_FIRST && !rd_en_i
      |=> $stable(state_ff.local_high))
      else $error("locked high byte changed");
   lock_release_a: assert property (rd_en_i && !rd_high && !rd_low
      |=> state_ff.lock == TLRB_UNLOCKED)
      else $error("other read left the lock set");
   timeout_bit_a: assert property (wr_en_i && addr_i == `TLRB_OFS_FAULT_CFG
      |=> bus_timeout_enable_o == $past(wdata_i[7]))
      else $error("timeout enable did not follow the write");
   single_fault_a: assert property (rmt_conv_i.done && rmt_below && cnt_field == 3'h0
      |=> limit_warning_o)
      else $error("single fault did not raise the warning");
   shut_cause_a: assert property ($rose(overtemp_shutdown_output_o)
      |-> $past(local_conv_i.done || rmt_conv_i.done))
      else $error("shutdown rose without a conversion");
   shut_hold_a: assert property (overtemp_shutdown_output_o && !local_conv_i.done
      && !rmt_conv_i.done |=> overtemp_shutdown_output_o)
      else $error("shutdown released without a conversion");

   // Read port: the data stands between reads and holes read zero.
   // The whole byte handed out is the one held at the read edge.
   rdata_hold_a: assert property (!rd_en_i |=> $stable(rdata_o))
      else $error("read data changed without a read");
   hole_read_a: assert property (rd_en_i && !addr_mapped |=> rdata_o == 8'h00)
      else $error("unmapped pointer did not read zero");
   high_read_a: assert property (rd_high |=> rdata_o == $past(state_ff.local_high))
      else $error("whole byte read back wrong");
   frac_nibble_a: assert property (state_ff.local_frac[3:0] == 4'h0)
      else $error("fraction byte low nibble not zero");

   // Writable bytes take the written value whole, reserved bits included,
   // on the edge after the strobe; a lost write would leave a stale limit
   // that the compares would go on using without any sign to the host.
   frac_write_a: assert property (wr_en_i && addr_i == `TLRB_OFS_RMT_LOW_FRAC
      |=> state_ff.rmt_low_frac == $past(wdata_i))
      else $error("low-limit fraction write lost");
   rmt_shut_write_a: assert property (wr_en_i && addr_i == `TLRB_OFS_RMT_SHUT
      |=> state_ff.rmt_shut == $past(wdata_i))
      else $error("remote shutdown limit write lost");
   local_shut_write_a: assert property (wr_en_i && addr_i == `TLRB_OFS_LOCAL_SHUT
      |=> state_ff.local_shut == $past(wdata_i))
      else $error("local shutdown limit write lost");
   band_write_a: assert property (wr_en_i && addr_i == `TLRB_OFS_DEADBAND
      |=> state_ff.deadband == $past(wdata_i))
      else $error("deadband write lost");
   cfg_write_a: assert property (wr_en_i && addr_i == `TLRB_OFS_FAULT_CFG
      |=> state_ff.fault_cfg == $past(wdata_i))
      else $error("fault config write lost");

   // Remote faults: one in-limit reading clears the warning at once, and
   // the counter never climbs past the largest count that can be asked for.
   warn_clear_a: assert property (rmt_conv_i.done && !rmt_below
      |=> !limit_warning_o)
      else $error("warning held after an in-limit reading");
   count_sat_a: assert property (state_ff.fault_cnt <= `TLRB_FAULT_MAX)
      else $error("fault counter ran past its ceiling");

   // Shutdown: a reading over either limit sets it on the next edge, and a
   // local reading below the release point clears it when the remote side
   // is cool; the sum is kept at nine bits so a large deadband cannot wrap.
   local_set_a: assert property (local_conv_i.done
      && local_conv_i.whole > state_ff.local_shut |=> overtemp_shutdown_output_o)
      else $error("local reading over limit did not shut down");
   rmt_set_a: assert property (rmt_conv_i.done
      && rmt_conv_i.whole > state_ff.rmt_shut |=> overtemp_shutdown_output_o)
      else $error("remote reading over limit did not shut down");
   local_release_a: assert property (local_conv_i.done && !rmt_conv_i.done
      && !state_ff.rmt_hot
      && (({1'b0, local_conv_i.whole} + {1'b0, state_ff.deadband})
          < {1'b0, state_ff.local_shut})
      |=> !overtemp_shutdown_output_o)
      else $error("shutdown held below the release point");

   // Lock pairing: the second half of a pair drops the lock, a repeat read
   // of the first half keeps it, and an unlocked conversion loads both.
   pair_unlock_a: assert property (rd_low && state_ff.lock == TLRB_HIGH_FIRST
      |=> state_ff.lock == TLRB_UNLOCKED)
      else $error("pair read left the lock set");
   lock_keep_a: assert property (rd_high && state_ff.lock == TLRB_HIGH_FIRST
      |=> state_ff.lock == TLRB_HIGH_FIRST)
      else $error("repeat high read dropped the lock");
   high_update_a: assert property (state_ff.lock == TLRB_UNLOCKED && !rd_en_i
      && local_conv_i.done |=> state_ff.local_high == $past(local_conv_i.whole))
      else $error("whole byte missed a conversion");

   high_low_c:  cover property (rd_high ##1 rd_low);
   low_high_c:  cover property (rd_low ##1 rd_high);
   shut_c:      cover property ($rose(overtemp_shutdown_output_o));
   warn_four_c: cover property (cnt_field == 3'h7 && $rose(limit_warning_o));
   pair_drop_c: cover property (rd_high ##1 (rd_en_i && !rd_high && !rd_low));

endmodule
